//--- design/vdop_pkg.sv
package vdop_pkg;

   // Bus geometry
   localparam int WB_ADR_W = 8;
   localparam int WB_DAT_W = 32;
   localparam int WB_SEL_W = 4;
   localparam int PIX_DAT_W = 8;

   // Register word addresses (byte addresses, one aligned word each)
   localparam logic [WB_ADR_W-1:0] ADR_CTRL = 8'h00;
   localparam logic [WB_ADR_W-1:0] ADR_HS_START = 8'h04;
   localparam logic [WB_ADR_W-1:0] ADR_HS_END = 8'h08;
   localparam logic [WB_ADR_W-1:0] ADR_STATUS = 8'h0c;

   // Control register fields
   localparam int CTRL_OE_BIT = 0;
   localparam int CTRL_BURST_BIT = 1;
   localparam int CTRL_SMU_BIT = 2;
   localparam int CTRL_SRST_BIT = 3;
   localparam int CTRL_FCS_LSB = 4;
   localparam int FCS_W = 3;

   // Status register fields
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_TRACK_BIT = 1;
   localparam int STAT_FIELD_BIT = 2;

   // Byte lane split of the 14-bit timing registers
   localparam int LANE_W = 8;

   // Sample range and line counts
   localparam logic [PIX_DAT_W-1:0] LUMA_MIN = 8'h10;
   localparam int LINE_CNT_W = 9;
   localparam logic [LINE_CNT_W-1:0] LINES_FREE_RUN = 9'h151;
   localparam int GOOD_CNT_W = 5;
   localparam logic [GOOD_CNT_W-1:0] LOCK_LINES = 5'h1e;
   localparam int MISS_CNT_W = 4;
   localparam logic [MISS_CNT_W-1:0] MISS_LIMIT_DEFAULT = 4'hc;
   localparam logic [MISS_CNT_W-1:0] MISS_LIMIT_SINGLE = 4'h1;

   // Soft reset length in clock cycles
   localparam int SRST_CNT_W = 3;
   localparam logic [SRST_CNT_W-1:0] SRST_CYCLES = 3'h4;

   // Field capture selection codes
   typedef enum logic [FCS_W-1:0] {
      VDOP_CAP_NONE = 3'b000,
      VDOP_CAP_EVERY4 = 3'b001,
      VDOP_CAP_EVERY2 = 3'b010,
      VDOP_CAP_EVERY2_ODD = 3'b011,
      VDOP_CAP_EVERY2_EVEN = 3'b100,
      VDOP_CAP_ODD = 3'b101,
      VDOP_CAP_EVEN = 3'b110,
      VDOP_CAP_ALL = 3'b111
   } vdop_cap_e;

endpackage : vdop_pkg

//--- design/vdop_lock.sv
`timescale 1ns/10ps
module vdop_lock (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Events from the line timer
   input wire logic clr_i,
   input wire logic hsync_i,
   input wire logic miss_i,
   input wire logic single_miss_unlock_i,
   // Lock state
   output logic locked_o,
   output logic tracking_o
);
   import vdop_pkg::*;

   typedef struct packed {
      logic [GOOD_CNT_W-1:0] good_cnt;
      logic [MISS_CNT_W-1:0] miss_cnt;
      logic locked;
      logic tracking;
   } vdop_lock_s;

   vdop_lock_s s;
   vdop_lock_s next_s;
   logic [MISS_CNT_W-1:0] miss_limit;

   // Miss limit follows the unlock setting
   assign miss_limit = single_miss_unlock_i ? MISS_LIMIT_SINGLE : MISS_LIMIT_DEFAULT;

   // Good syncs build lock, missing syncs tear it down
   always_comb begin
      next_s = s;
      if (clr_i) begin
         next_s = '0;
      end else if (hsync_i) begin
         next_s.miss_cnt = '0;
         next_s.tracking = 1'b1;
         if (s.good_cnt != LOCK_LINES) begin
            next_s.good_cnt = s.good_cnt + 1'b1;
         end
         if (s.good_cnt == LOCK_LINES - 1'b1) begin
            next_s.locked = 1'b1;
         end
      end else if (miss_i && s.tracking) begin
         // Only count misses while a reference exists; free-run lines while not tracking are not misses
         if (s.miss_cnt + 1'b1 >= miss_limit) begin
            next_s = '0;
         end else begin
            next_s.miss_cnt = s.miss_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign locked_o = s.locked;
   assign tracking_o = s.tracking;

   default clocking lk_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // Lock loss must come on the limiting miss
   AST_SINGLE_MISS_UNLOCK: assert property (ce_i && !clr_i && !hsync_i && miss_i && s.tracking && single_miss_unlock_i
      |=> !locked_o && !tracking_o) else $error("single miss did not drop lock");
   AST_MISS_BOUND: assert property (s.miss_cnt < MISS_LIMIT_DEFAULT)
      else $error("miss count passed twelve");
   AST_LOCK_AFTER_LINES: assert property (ce_i && !clr_i && hsync_i && s.good_cnt == LOCK_LINES - 1'b1
      |=> locked_o) else $error("lock not taken after thirty lines");
   COV_LOCKED: cover property ($rose(locked_o));

endmodule : vdop_lock

//--- design/vdop_out.sv
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
// How it works
// - Chroma bus passes full 0..255 unsigned codes
// - Chroma alternates Cb/Cr, each line starts Cb
// - Luma samples clamped to 16..255 unsigned; burst chroma bytes on the luma bus are not
// - Valid strobe high exactly with sample data
// - Control outputs float after hard/soft reset
// - Line sync from hsync, else counter overflow
// - Software sets line sync start and end
// - Frame sync from vsync, else line overflow
// - Field pin low odd, high even
// - No vsync: field toggles after 337 lines
// - Active flag high during active line samples
// - Burst mode holds active flag high
// - Active flag free-running, clocked, capture-independent
// - Lock lost within twelve missing syncs default
// - Lock reached about thirty lines after acquisition
// - Drive enable gates all pixel port pins, not the Wishbone outputs; resets clear
// - Mode bit: set burst 8-bit, clear 16-bit
// - Single-miss bit drops lock after one miss
// - All outputs change on master clock
module vdop_out #(
   parameter int LINE_CYCLES = 7944,
   parameter int PIX_W = 14
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [vdop_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [vdop_pkg::WB_SEL_W-1:0] wb_sel_i,
   input wire logic [vdop_pkg::WB_DAT_W-1:0] wb_dat_i,
   output logic [vdop_pkg::WB_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Decoded video from the decoder core
   input wire logic [vdop_pkg::PIX_DAT_W-1:0] luma_i,
   input wire logic [vdop_pkg::PIX_DAT_W-1:0] cb_i,
   input wire logic [vdop_pkg::PIX_DAT_W-1:0] cr_i,
   input wire logic sample_valid_i,
   input wire logic active_i,
   input wire logic hsync_det_i,
   input wire logic vsync_det_i,
   input wire logic vsync_even_i,
   // Pixel port pins
   output logic [vdop_pkg::PIX_DAT_W-1:0] luma_o,
   output logic luma_oe_o,
   output logic [vdop_pkg::PIX_DAT_W-1:0] chroma_sample_bus_o,
   output logic chroma_sample_bus_oe_o,
   output logic output_valid_strobe_o,
   output logic output_valid_strobe_oe_o,
   output logic line_sync_o,
   output logic line_sync_oe_o,
   output logic frame_sync_o,
   output logic frame_sync_oe_o,
   output logic field_o,
   output logic field_oe_o,
   output logic active_o,
   output logic active_oe_o
);
   import vdop_pkg::*;

   localparam logic [PIX_W-1:0] LINE_LAST = PIX_W'(LINE_CYCLES - 1);
   localparam logic [PIX_W-1:0] HS_START_RST = 14'h0000;
   localparam logic [PIX_W-1:0] HS_END_RST = 14'h0100;

   typedef struct packed {
      logic oe;
      logic burst;
      logic smu;
      vdop_cap_e fcs;
      logic [PIX_W-1:0] hs_start;
      logic [PIX_W-1:0] hs_end;
      logic [SRST_CNT_W-1:0] srst_cnt;
      logic ack;
      logic [WB_DAT_W-1:0] rdata;
      logic [PIX_W-1:0] pix_cnt;
      logic [LINE_CNT_W-1:0] line_cnt;
      logic [1:0] field_seq;
      logic phase;
      logic pend;
      logic [PIX_DAT_W-1:0] pend_luma;
      logic [PIX_DAT_W-1:0] luma;
      logic [PIX_DAT_W-1:0] chroma;
      logic valid;
      logic lsync;
      logic fsync;
      logic field;
      logic active;
   } vdop_state_s;

   function automatic vdop_state_s rst_state();
      vdop_state_s r;
      r = '0;
      r.hs_start = HS_START_RST;
      r.hs_end = HS_END_RST;
      return r;
   endfunction : rst_state

   // Field capture decision for the field being output
   function automatic logic cap_ok(input vdop_cap_e fcs, input logic field, input logic [1:0] seq);
      logic ok;
      ok = 1'b0;
      case (fcs)
         VDOP_CAP_NONE: ok = 1'b0;
         VDOP_CAP_EVERY4: ok = (seq == 2'h0);
         VDOP_CAP_EVERY2: ok = !seq[0];
         VDOP_CAP_EVERY2_ODD: ok = !field && !seq[1];
         VDOP_CAP_EVERY2_EVEN: ok = field && !seq[1];
         VDOP_CAP_ODD: ok = !field;
         VDOP_CAP_EVEN: ok = field;
         VDOP_CAP_ALL: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : cap_ok

   // Keep luma codes out of the sync range
   function automatic logic [PIX_DAT_W-1:0] clamp_luma(input logic [PIX_DAT_W-1:0] y);
      return (y < LUMA_MIN) ? LUMA_MIN : y;
   endfunction : clamp_luma

   vdop_state_s s;
   vdop_state_s next_s;
   logic line_start;
   logic line_miss;
   logic srst_active;
   logic bus_req;
   logic capture;
   logic phase_use;
   logic locked;
   logic tracking;

   // Line ends on a detected sync, or on counter overflow when none comes
   assign line_start = hsync_det_i || (s.pix_cnt == LINE_LAST);
   assign line_miss = !hsync_det_i && (s.pix_cnt == LINE_LAST);
   assign srst_active = (s.srst_cnt != '0);
   assign bus_req = wb_cyc_i && wb_stb_i && !s.ack;
   assign capture = cap_ok(s.fcs, s.field, s.field_seq);
   // A sample in the line's first cycle already takes the Cb slot
   assign phase_use = line_start ? 1'b0 : s.phase;

   vdop_lock u_lock (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .clr_i(srst_active),
      .hsync_i(hsync_det_i),
      .miss_i(line_miss),
      .single_miss_unlock_i(s.smu),
      .locked_o(locked),
      .tracking_o(tracking)
   );

   // Next-state logic for bus, timing and sample path
   always_comb begin
      next_s = s;
      // Wishbone: one-cycle answer, ack drops the cycle after
      next_s.ack = bus_req;
      next_s.rdata = '0;
      if (bus_req && wb_we_i) begin
         if (wb_adr_i == ADR_CTRL) begin
            if (wb_sel_i[0]) begin
               next_s.oe = wb_dat_i[CTRL_OE_BIT];
               next_s.burst = wb_dat_i[CTRL_BURST_BIT];
               next_s.smu = wb_dat_i[CTRL_SMU_BIT];
               next_s.fcs = vdop_cap_e'(wb_dat_i[CTRL_FCS_LSB +: FCS_W]);
               if (wb_dat_i[CTRL_SRST_BIT]) begin
                  next_s.srst_cnt = SRST_CYCLES;
               end
            end
         end else if (wb_adr_i == ADR_HS_START) begin
            if (wb_sel_i[0]) begin
               next_s.hs_start[LANE_W-1:0] = wb_dat_i[LANE_W-1:0];
            end
            if (wb_sel_i[1]) begin
               next_s.hs_start[PIX_W-1:LANE_W] = wb_dat_i[PIX_W-1:LANE_W];
            end
         end else if (wb_adr_i == ADR_HS_END) begin
            if (wb_sel_i[0]) begin
               next_s.hs_end[LANE_W-1:0] = wb_dat_i[LANE_W-1:0];
            end
            if (wb_sel_i[1]) begin
               next_s.hs_end[PIX_W-1:LANE_W] = wb_dat_i[PIX_W-1:LANE_W];
            end
         end
      end else if (bus_req) begin
         if (wb_adr_i == ADR_CTRL) begin
            next_s.rdata[CTRL_OE_BIT] = s.oe;
            next_s.rdata[CTRL_BURST_BIT] = s.burst;
            next_s.rdata[CTRL_SMU_BIT] = s.smu;
            next_s.rdata[CTRL_SRST_BIT] = srst_active;
            next_s.rdata[CTRL_FCS_LSB +: FCS_W] = s.fcs;
         end else if (wb_adr_i == ADR_HS_START) begin
            next_s.rdata[PIX_W-1:0] = s.hs_start;
         end else if (wb_adr_i == ADR_HS_END) begin
            next_s.rdata[PIX_W-1:0] = s.hs_end;
         end else if (wb_adr_i == ADR_STATUS) begin
            next_s.rdata[STAT_LOCK_BIT] = locked;
            next_s.rdata[STAT_TRACK_BIT] = tracking;
            next_s.rdata[STAT_FIELD_BIT] = s.field;
         end
      end

      // Pixel counter restarts each line, hsync or free-run
      next_s.pix_cnt = line_start ? '0 : s.pix_cnt + 1'b1;
      // Registered window compare; a window with end not after start stays low
      next_s.lsync = (s.pix_cnt >= s.hs_start) && (s.pix_cnt < s.hs_end);

      // Field and frame timing; a detected vsync outranks the free-run count
      if (vsync_det_i) begin
         next_s.field = vsync_even_i;
         next_s.line_cnt = '0;
         next_s.field_seq = s.field_seq + 1'b1;
         next_s.fsync = 1'b1;
      end else if (line_start) begin
         next_s.fsync = 1'b0;
         if (s.line_cnt == LINES_FREE_RUN - 1'b1) begin
            next_s.field = !s.field;
            next_s.line_cnt = '0;
            next_s.field_seq = s.field_seq + 1'b1;
            next_s.fsync = 1'b1;
         end else begin
            next_s.line_cnt = s.line_cnt + 1'b1;
         end
      end

      // Sample path; phase runs even for skipped fields so Cb stays first
      next_s.valid = 1'b0;
      if (line_start) begin
         next_s.phase = 1'b0;
      end
      if (sample_valid_i) begin
         next_s.phase = !phase_use;
      end
      if (s.burst) begin
         // Burst: chroma byte then its luma on one bus; a sample during the luma byte is dropped
         if (s.pend) begin
            next_s.luma = s.pend_luma;
            next_s.valid = 1'b1;
            next_s.pend = 1'b0;
         end else if (sample_valid_i && capture) begin
            next_s.luma = phase_use ? cr_i : cb_i;
            next_s.valid = 1'b1;
            next_s.pend = 1'b1;
            next_s.pend_luma = clamp_luma(luma_i);
         end
      end else begin
         next_s.pend = 1'b0;
         if (sample_valid_i && capture) begin
            next_s.luma = clamp_luma(luma_i);
            next_s.chroma = phase_use ? cr_i : cb_i;
            next_s.valid = 1'b1;
         end
      end
      // Active flag runs whatever the capture setting
      next_s.active = s.burst ? 1'b1 : active_i;

      // Soft reset returns everything but the bus ack and its own countdown to reset values; read data returns zero
      if (srst_active) begin
         next_s = rst_state();
         next_s.ack = bus_req;
         next_s.srst_cnt = s.srst_cnt - 1'b1;
      end
   end

   // Single register stage; every pin leaves a flip-flop on the master clock
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         s <= rst_state();
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // Pin drivers straight from state
   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
   assign luma_o = s.luma;
   assign chroma_sample_bus_o = s.chroma;
   assign output_valid_strobe_o = s.valid;
   assign line_sync_o = s.lsync;
   assign frame_sync_o = s.fsync;
   assign field_o = s.field;
   assign active_o = s.active;
   // One enable flop drives every pin enable
   assign luma_oe_o = s.oe;
   assign chroma_sample_bus_oe_o = s.oe;
   assign output_valid_strobe_oe_o = s.oe;
   assign line_sync_oe_o = s.oe;
   assign frame_sync_oe_o = s.oe;
   assign field_oe_o = s.oe;
   assign active_oe_o = s.oe;

   default clocking out_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   AST_FLOAT_AFTER_RESET: assert property (ce_i && srst_active |=> !active_oe_o && !field_oe_o && !line_sync_oe_o)
      else $error("outputs driven during soft reset");
   AST_SRST_FOUR: assert property (ce_i && bus_req && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]
      && wb_dat_i[CTRL_SRST_BIT] && !srst_active |=> srst_active [*4] ##1 !srst_active)
      else $error("soft reset length wrong");
   AST_LUMA_RANGE: assert property (output_valid_strobe_o && !s.burst |-> luma_o >= LUMA_MIN)
      else $error("luma below sixteen");
   AST_FIRST_CB: assert property (ce_i && !srst_active && line_start && sample_valid_i && capture && !s.burst
      |=> chroma_sample_bus_o == $past(cb_i)) else $error("line did not start with Cb");
   AST_VALID_CAUSE: assert property (ce_i && !srst_active ##1 output_valid_strobe_o
      |-> $past(sample_valid_i) || $past(s.pend)) else $error("valid without sample");
   AST_ACTIVE_BURST: assert property (ce_i && !srst_active && s.burst |=> active_o)
      else $error("active low in burst mode");
   AST_ACTIVE_FOLLOW: assert property (ce_i && !srst_active && !s.burst |=> active_o == $past(active_i))
      else $error("active flag not following video");
   AST_FREE_FIELD: assert property (ce_i && !srst_active && !vsync_det_i && line_start
      && s.line_cnt == LINES_FREE_RUN - 1'b1 |=> field_o != $past(field_o) && frame_sync_o)
      else $error("field did not toggle after 337 lines");
   AST_VSYNC_FIELD: assert property (ce_i && !srst_active && vsync_det_i
      |=> frame_sync_o && field_o == $past(vsync_even_i)) else $error("vsync not followed");
   AST_LINE_WINDOW: assert property (ce_i && !srst_active
      |=> line_sync_o == ($past(s.pix_cnt) >= $past(s.hs_start) && $past(s.pix_cnt) < $past(s.hs_end)))
      else $error("line sync outside window");
   AST_FREE_LINE: assert property (ce_i && !srst_active && !hsync_det_i && s.pix_cnt == LINE_LAST
      |=> s.pix_cnt == '0) else $error("free-run line did not wrap");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

   COV_BURST_VALID: cover property (s.burst && output_valid_strobe_o ##1 output_valid_strobe_o);
   COV_FREE_FIELD: cover property (!vsync_det_i && line_start && s.line_cnt == LINES_FREE_RUN - 1'b1);
   COV_SOFT_RESET: cover property ($fell(srst_active));
   COV_DRIVEN: cover property ($rose(active_oe_o));

endmodule : vdop_out

//--- testbench/vdop_store.sv
`timescale 1ns/10ps
module vdop_store (
   // Clock
   input wire logic sys_clk_i,
   // Pixel port pins and the shared drive enable
   input wire logic [vdop_pkg::PIX_DAT_W-1:0] luma_i,
   input wire logic [vdop_pkg::PIX_DAT_W-1:0] chroma_i,
   input wire logic valid_i,
   input wire logic oe_i,
   // What the store has kept
   output logic [15:0] count_o,
   output logic [vdop_pkg::PIX_DAT_W-1:0] luma_o,
   output logic [vdop_pkg::PIX_DAT_W-1:0] chroma_o
);
   import vdop_pkg::*;
   logic valid_pin;
   // Board pull-up: a floating strobe reads high, so the enable must gate it
   assign valid_pin = oe_i ? valid_i : 1'b1;
   initial begin
      count_o = 16'h0000;
      luma_o = 8'h00;
      chroma_o = 8'h00;
   end
   // Keep a sample only on a driven, asserted strobe
   always @(posedge sys_clk_i) begin
      if (oe_i === 1'b1 && valid_pin === 1'b1) begin
         count_o <= count_o + 16'h0001;
         luma_o <= luma_i;
         chroma_o <= chroma_i;
      end
   end
endmodule : vdop_store

//--- testbench/video_decoder_output_port_bench.sv
`timescale 1ns/10ps
module video_decoder_output_port_bench;
   import vdop_pkg::*;
   localparam int LC = 64;
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dwr = 32'h0, drd, q;
   logic [7:0] y = 8'h00, cb = 8'h00, cr = 8'h00, luma_o, chroma_o, st_y, st_c;
   logic sv = 1'b0, act = 1'b0, hs = 1'b0, vs = 1'b0, ve = 1'b0;
   logic y_oe, c_oe, dv, dv_oe, ls, ls_oe, fs, fs_oe, fld, fld_oe, act_o, act_oe;
   logic [15:0] st_n;
   int bad_count = 0, n_checks = 0;
   // Master clock, 8 ns
   always #4 sys_clk_i = ~sys_clk_i;
   vdop_out #(.LINE_CYCLES(LC), .PIX_W(14)) vdop_out_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr),
      .wb_dat_o(drd), .wb_ack_o(ack), .luma_i(y), .cb_i(cb), .cr_i(cr), .sample_valid_i(sv),
      .active_i(act), .hsync_det_i(hs), .vsync_det_i(vs), .vsync_even_i(ve), .luma_o(luma_o),
      .luma_oe_o(y_oe), .chroma_sample_bus_o(chroma_o), .chroma_sample_bus_oe_o(c_oe),
      .output_valid_strobe_o(dv), .output_valid_strobe_oe_o(dv_oe), .line_sync_o(ls), .line_sync_oe_o(ls_oe),
      .frame_sync_o(fs), .frame_sync_oe_o(fs_oe), .field_o(fld), .field_oe_o(fld_oe), .active_o(act_o),
      .active_oe_o(act_oe));
   // Far-side store watches the pins
   vdop_store vdop_store_i (.sys_clk_i(sys_clk_i), .luma_i(luma_o), .chroma_i(chroma_o), .valid_i(dv),
      .oe_i(dv_oe), .count_o(st_n), .luma_o(st_y), .chroma_o(st_c));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : tick

   // One classic cycle; ack and read data are taken at the edge that sees ack high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dwr <= d; sel <= 4'h3;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = drd;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         close_out();
      end
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd

   // One sample cycle from the decoder core
   task automatic pix(input logic h, input logic [7:0] yy, input logic [7:0] b, input logic [7:0] r);
      @(posedge sys_clk_i);
      sv <= 1'b1; hs <= h; y <= yy; cb <= b; cr <= r;
      @(posedge sys_clk_i);
      sv <= 1'b0; hs <= 1'b0;
   endtask : pix

   task automatic vsync(input logic e);
      @(posedge sys_clk_i);
      vs <= 1'b1; ve <= e;
      @(posedge sys_clk_i);
      vs <= 1'b0;
      @(posedge sys_clk_i);
      chk({fs, fld}, {1'b1, e});
   endtask : vsync

   task automatic lines(input int n);
      repeat (n) begin
         @(posedge sys_clk_i);
         hs <= 1'b1;
         @(posedge sys_clk_i);
         hs <= 1'b0;
         tick(38);
      end
   endtask : lines

   task automatic t_reset;
      chk({y_oe, c_oe, dv_oe, ls_oe, fs_oe, fld_oe, act_oe}, 32'h0);
      rd(ADR_CTRL, 32'h0);
      rd(ADR_HS_START, 32'h0);
      rd(ADR_HS_END, 32'h100);
      rd(ADR_STATUS, 32'h0);
      wb(1'b1, 8'h40, 32'hff);
      rd(8'h40, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_samples;
      wb(1'b1, ADR_CTRL, 32'h71);
      chk({y_oe, c_oe, dv_oe, ls_oe, fs_oe, fld_oe, act_oe}, 32'h7f);
      pix(1'b1, 8'h05, 8'hff, 8'h33);
      tick(1);
      chk({dv, luma_o, chroma_o}, {1'b1, LUMA_MIN, 8'hff});
      tick(1);
      chk(dv, 1'b0);
      pix(1'b0, 8'hff, 8'h11, 8'h00);
      tick(1);
      chk({dv, luma_o, chroma_o}, {1'b1, 8'hff, 8'h00});
      tick(2);
      chk({st_n, st_y, st_c}, {16'h0002, 8'hff, 8'h00});
      // Capture stays on but the pins float, so the store must not take the sample
      wb(1'b1, ADR_CTRL, 32'h70);
      pix(1'b0, 8'h20, 8'h21, 8'h22);
      tick(2);
      chk({dv_oe, st_n}, {1'b0, 16'h0002});
      $display("test samples done");
   endtask : t_samples

   task automatic t_field;
      wb(1'b1, ADR_CTRL, 32'h51);
      vsync(1'b1);
      pix(1'b1, 8'h40, 8'h41, 8'h42);
      tick(1);
      chk(dv, 1'b0);
      vsync(1'b0);
      pix(1'b1, 8'h40, 8'h41, 8'h42);
      tick(1);
      chk(dv, 1'b1);
      $display("test field done");
   endtask : t_field

   task automatic t_sync_active;
      int n;
      n = 0;
      wb(1'b1, ADR_HS_START, 32'h4);
      wb(1'b1, ADR_HS_END, 32'h8);
      rd(ADR_HS_END, 32'h8);
      tick(2);
      repeat (LC) begin
         @(posedge sys_clk_i);
         if (ls === 1'b1)
            n++;
      end
      chk(n, 32'h4);
      wb(1'b1, ADR_CTRL, 32'h01);
      @(posedge sys_clk_i);
      act <= 1'b1;
      tick(3);
      chk(act_o, 1'b1);
      act <= 1'b0;
      tick(3);
      chk(act_o, 1'b0);
      wb(1'b1, ADR_CTRL, 32'h73);
      tick(3);
      chk(act_o, 1'b1);
      pix(1'b1, 8'h90, 8'h21, 8'h22);
      tick(1);
      chk({dv, luma_o}, {1'b1, 8'h21});
      tick(1);
      chk(luma_o, 32'h90);
      $display("test sync and active done");
   endtask : t_sync_active

   task automatic t_lock;
      wb(1'b1, ADR_CTRL, 32'h01);
      // Earlier scenarios left a few good syncs behind; let twelve misses clear them first
      tick(13 * LC);
      lines(28);
      rd(ADR_STATUS, 32'h2);
      lines(4);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(q[1:0], 2'b11);
      tick(5 * LC);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(q[0], 1'b1);
      tick(9 * LC);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(q[0], 1'b0);
      lines(32);
      wb(1'b1, ADR_CTRL, 32'h05);
      tick(2 * LC);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(q[0], 1'b0);
      $display("test lock done");
   endtask : t_lock

   task automatic t_soft;
      // Set drive, burst and single-miss with the reset so the reset has something to clear
      wb(1'b1, ADR_CTRL, 32'h0f);
      tick(6);
      chk({y_oe, c_oe, dv_oe, ls_oe, fs_oe, fld_oe, act_oe}, 32'h0);
      rd(ADR_CTRL, 32'h0);
      rd(ADR_HS_END, 32'h100);
      wb(1'b1, ADR_CTRL, 32'h01);
      tick(330 * LC);
      chk(fld, 1'b0);
      tick(10 * LC);
      chk(fld, 1'b1);
      $display("test soft reset done");
   endtask : t_soft

   // Main sequence
   initial begin
      tick(10);
      rst_b_i <= 1'b1;
      tick(1);
      t_reset();
      t_samples();
      t_field();
      t_sync_active();
      t_lock();
      t_soft();
      close_out();
   end
endmodule : video_decoder_output_port_bench
